//--- core/rsti_params.svh
`ifndef RSTI_PARAMS_SVH
`define RSTI_PARAMS_SVH

// Register offsets
`define RSTI_OFF_STATUS 8'h0f
`define RSTI_OFF_AGING 8'h10
`define RSTI_OFF_TEMP_INT 8'h11
`define RSTI_OFF_TEMP_FRAC 8'h12
`define RSTI_PTR_LAST 8'h12

// Status field positions
`define RSTI_ST_OSF_BIT 7
`define RSTI_ST_EN32_BIT 3
`define RSTI_ST_BUSY_BIT 2
`define RSTI_ST_A2F_BIT 1
`define RSTI_ST_A1F_BIT 0

// Reset values
`define RSTI_RST_OSF 1'b1
`define RSTI_RST_EN32 1'b1
`define RSTI_RST_AGING 8'h00
`define RSTI_RST_TEMP 10'h000
`define RSTI_RST_PTR 8'h00

// Slave address
`define RSTI_SLAVE_ADDR 7'h68

// Timing
`define RSTI_CLK_PERIOD_NS 4
`define RSTI_NS_PER_S 1000000000
`define RSTI_FORCE_CONVERSION_PERIOD_S 64

`endif

//--- core/rsti_pkg.sv
package rsti_pkg;

   // Serial slave states, Gray-coded along the usual path
   typedef enum logic [2:0] {
      RSTI_IDLE = 3'h0,
      RSTI_ADDR = 3'h1,
      RSTI_ACK_ADDR = 3'h3,
      RSTI_WRITE = 3'h2,
      RSTI_ACK_WRITE = 3'h6,
      RSTI_READ = 3'h7,
      RSTI_ACK_READ = 3'h5
   } rsti_state_t;

endpackage : rsti_pkg

//--- core/rsti_top.sv
`timescale 1ns/1ns
`include "rsti_params.svh"

module rsti_top
   import rsti_pkg::*;
#(
   parameter int CYCLES_PER_SEC = `RSTI_NS_PER_S / `RSTI_CLK_PERIOD_NS,
   parameter int FORCE_CONVERSION_PERIOD_S = `RSTI_FORCE_CONVERSION_PERIOD_S
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST,
   // Serial bus
   input wire logic SCL,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE,
   // Oscillator and fixed clock pin
   input wire logic OSC_RUNNING,
   input wire logic OSC_WAVE_32K,
   output logic FIXED_CLK_O,
   output logic FIXED_CLK_OE,
   // Alarms and interrupt pin
   input wire logic FIRST_ALARM_MATCH,
   input wire logic SECOND_ALARM_MATCH,
   input wire logic FIRST_ALARM_IRQ_ENABLE,
   input wire logic SECOND_ALARM_IRQ_ENABLE,
   input wire logic IRQ_OR_WAVE_SELECT,
   output logic IRQ_WAVE_PIN_OE,
   // Temperature and compensation
   input wire logic ON_BATTERY,
   input wire logic FORCE_CONVERSION,
   input wire logic COMP_IDLE,
   input wire logic TEMP_DONE,
   input wire logic [9:0] TEMP_CODE,
   output logic TEMP_FORCE_CONVERSION_REQ,
   output logic TRIM_APPLY,
   output logic [7:0] CAP_TRIM
);

   localparam int SEC_W = $clog2(CYCLES_PER_SEC + 1);
   localparam int PER_W = $clog2(FORCE_CONVERSION_PERIOD_S + 1);

   generate
      if (CYCLES_PER_SEC < 2 || FORCE_CONVERSION_PERIOD_S < 1) begin : g_bad_param
         $error("rsti_top: counts too small");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers: SCL, SDA, oscillator running, 32k wave, battery

   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;
   logic scl_prev_reg;
   logic sda_prev_reg;
   logic scl_s;
   logic sda_s;
   logic osc_run_s;
   logic wave_s;
   logic batt_s;

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         sync1_reg <= 5'h1b;
         sync2_reg <= 5'h1b;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         sync1_reg <= {SCL, SDA_I, OSC_RUNNING, OSC_WAVE_32K, ON_BATTERY};
         sync2_reg <= sync1_reg;
         scl_prev_reg <= sync2_reg[4];
         sda_prev_reg <= sync2_reg[3];
      end
   end

   assign scl_s = sync2_reg[4];
   assign sda_s = sync2_reg[3];
   assign osc_run_s = sync2_reg[2];
   assign wave_s = sync2_reg[1];
   assign batt_s = sync2_reg[0];

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;

   assign scl_rise = scl_s & ~scl_prev_reg;
   assign scl_fall = ~scl_s & scl_prev_reg;
   assign start_cond = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
   assign stop_cond = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

   ////////////////////////////////////////////////////////////////////////////////
   // Register state

   logic osf_reg;
   logic en32_reg;
   logic busy_reg;
   logic a2f_reg;
   logic a1f_reg;
   logic [7:0] aging_reg;
   logic [9:0] temp_reg;
   logic [7:0] status_val;

   assign status_val = {osf_reg, 3'h0, en32_reg, busy_reg, a2f_reg, a1f_reg};

   function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] st,
                                           input logic [7:0] ag, input logic [9:0] t);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         `RSTI_OFF_STATUS: r = st;
         `RSTI_OFF_AGING: r = ag;
         `RSTI_OFF_TEMP_INT: r = t[9:2];
         `RSTI_OFF_TEMP_FRAC: r = {t[1:0], 6'h00};
         default: r = 8'h00;
      endcase
      return r;
   endfunction : read_mux

   ////////////////////////////////////////////////////////////////////////////////
   // Serial slave: receive, transmit, pointer

   rsti_state_t state_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [3:0] bitcnt_reg;
   logic rw_reg;
   logic first_reg;
   logic nack_reg;
   logic [7:0] ptr_reg;
   logic sda_oe_reg;
   logic wr_stb_reg;
   logic [7:0] wr_addr_reg;
   logic [7:0] wr_data_reg;
   logic batt_access_reg;
   logic [7:0] rd_val;
   logic [7:0] ptr_inc;

   assign rd_val = read_mux(ptr_reg, status_val, aging_reg, temp_reg);
   // Pointer runs through the map and wraps to the bottom after the last register
   assign ptr_inc = (ptr_reg == `RSTI_PTR_LAST) ? 8'h00 : ptr_reg + 8'h01;

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         state_reg <= RSTI_IDLE;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         bitcnt_reg <= 4'h0;
         rw_reg <= 1'b0;
         first_reg <= 1'b0;
         nack_reg <= 1'b0;
         ptr_reg <= `RSTI_RST_PTR;
         sda_oe_reg <= 1'b0;
         wr_stb_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         wr_data_reg <= 8'h00;
         batt_access_reg <= 1'b0;
      end else begin
         wr_stb_reg <= 1'b0;
         batt_access_reg <= 1'b0;
         if (stop_cond) begin
            state_reg <= RSTI_IDLE;
            sda_oe_reg <= 1'b0;
         end else if (start_cond) begin
            // Repeated START keeps the pointer so a read can follow a pointer write
            state_reg <= RSTI_ADDR;
            bitcnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
         end else if (scl_rise) begin
            case (state_reg)
               RSTI_ADDR, RSTI_WRITE, RSTI_READ: begin
                  shift_reg <= {shift_reg[6:0], sda_s};
                  bitcnt_reg <= bitcnt_reg + 4'h1;
               end
               RSTI_ACK_READ: nack_reg <= sda_s;
               default: ;
            endcase
         end else if (scl_fall) begin
            case (state_reg)
               RSTI_ADDR: begin
                  if (bitcnt_reg == 4'h8) begin
                     if (shift_reg[7:1] == `RSTI_SLAVE_ADDR) begin
                        state_reg <= RSTI_ACK_ADDR;
                        sda_oe_reg <= 1'b1;
                        rw_reg <= shift_reg[0];
                        batt_access_reg <= batt_s;
                     end else begin
                        state_reg <= RSTI_IDLE;
                     end
                  end
               end
               RSTI_ACK_ADDR: begin
                  bitcnt_reg <= 4'h0;
                  if (rw_reg) begin
                     state_reg <= RSTI_READ;
                     tx_reg <= {rd_val[6:0], 1'b0};
                     sda_oe_reg <= ~rd_val[7];
                  end else begin
                     state_reg <= RSTI_WRITE;
                     first_reg <= 1'b1;
                     sda_oe_reg <= 1'b0;
                  end
               end
               RSTI_WRITE: begin
                  if (bitcnt_reg == 4'h8) begin
                     state_reg <= RSTI_ACK_WRITE;
                     sda_oe_reg <= 1'b1;
                     first_reg <= 1'b0;
                     if (first_reg) begin
                        ptr_reg <= shift_reg;
                     end else begin
                        wr_stb_reg <= 1'b1;
                        wr_addr_reg <= ptr_reg;
                        wr_data_reg <= shift_reg;
                        ptr_reg <= ptr_inc;
                     end
                  end
               end
               RSTI_ACK_WRITE: begin
                  state_reg <= RSTI_WRITE;
                  bitcnt_reg <= 4'h0;
                  sda_oe_reg <= 1'b0;
               end
               RSTI_READ: begin
                  if (bitcnt_reg == 4'h8) begin
                     state_reg <= RSTI_ACK_READ;
                     sda_oe_reg <= 1'b0;
                     ptr_reg <= ptr_inc;
                  end else begin
                     sda_oe_reg <= ~tx_reg[7];
                     tx_reg <= {tx_reg[6:0], 1'b0};
                  end
               end
               RSTI_ACK_READ: begin
                  bitcnt_reg <= 4'h0;
                  if (nack_reg) begin
                     state_reg <= RSTI_IDLE;
                     sda_oe_reg <= 1'b0;
                  end else begin
                     state_reg <= RSTI_READ;
                     tx_reg <= {rd_val[6:0], 1'b0};
                     sda_oe_reg <= ~rd_val[7];
                  end
               end
               RSTI_IDLE: sda_oe_reg <= 1'b0;
               default: begin
                  state_reg <= RSTI_IDLE;
                  sda_oe_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status flags and trim register; hardware set wins over a clearing write

   logic wr_status;
   logic wr_aging;

   assign wr_status = wr_stb_reg & (wr_addr_reg == `RSTI_OFF_STATUS);
   assign wr_aging = wr_stb_reg & (wr_addr_reg == `RSTI_OFF_AGING);

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         osf_reg <= `RSTI_RST_OSF;
         en32_reg <= `RSTI_RST_EN32;
         a2f_reg <= 1'b0;
         a1f_reg <= 1'b0;
         aging_reg <= `RSTI_RST_AGING;
      end else begin
         if (!osc_run_s) begin
            osf_reg <= 1'b1;
         end else if (wr_status) begin
            osf_reg <= osf_reg & wr_data_reg[`RSTI_ST_OSF_BIT];
         end
         if (wr_status) begin
            en32_reg <= wr_data_reg[`RSTI_ST_EN32_BIT];
         end
         if (SECOND_ALARM_MATCH) begin
            a2f_reg <= 1'b1;
         end else if (wr_status) begin
            a2f_reg <= a2f_reg & wr_data_reg[`RSTI_ST_A2F_BIT];
         end
         if (FIRST_ALARM_MATCH) begin
            a1f_reg <= 1'b1;
         end else if (wr_status) begin
            a1f_reg <= a1f_reg & wr_data_reg[`RSTI_ST_A1F_BIT];
         end
         if (wr_aging) begin
            aging_reg <= wr_data_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pins: fixed clock, interrupt, data line

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         FIXED_CLK_O <= 1'b0;
         FIXED_CLK_OE <= 1'b0;
         IRQ_WAVE_PIN_OE <= 1'b0;
         SDA_O <= 1'b0;
      end else begin
         FIXED_CLK_O <= wave_s;
         FIXED_CLK_OE <= en32_reg & osc_run_s;
         // Pin is active low: enabling the driver pulls it down
         IRQ_WAVE_PIN_OE <= IRQ_OR_WAVE_SELECT &
                            ((a2f_reg & SECOND_ALARM_IRQ_ENABLE) |
                             (a1f_reg & FIRST_ALARM_IRQ_ENABLE));
         SDA_O <= 1'b0;
      end
   end

   assign SDA_OE = sda_oe_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Conversion scheduling: power-up, battery access, 64 s period, forced

   logic [SEC_W-1:0] sec_cnt_reg;
   logic [PER_W-1:0] per_cnt_reg;
   logic period_tick;
   logic powerup_reg;
   logic forced_reg;
   logic force_conversion_start;

   // Split into a seconds prescaler and a seconds counter: one flat count
   // of the period would not fit 32 bits at this clock rate
   assign period_tick = (sec_cnt_reg == SEC_W'(CYCLES_PER_SEC - 1)) &&
                        (per_cnt_reg == PER_W'(FORCE_CONVERSION_PERIOD_S - 1));

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         sec_cnt_reg <= '0;
         per_cnt_reg <= '0;
      end else if (sec_cnt_reg == SEC_W'(CYCLES_PER_SEC - 1)) begin
         sec_cnt_reg <= '0;
         per_cnt_reg <= period_tick ? '0 : per_cnt_reg + PER_W'(1);
      end else begin
         sec_cnt_reg <= sec_cnt_reg + SEC_W'(1);
      end
   end

   // A forced request is dropped while a conversion is already running
   assign force_conversion_start = ~busy_reg &
                       (powerup_reg | period_tick | batt_access_reg | FORCE_CONVERSION);

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         powerup_reg <= 1'b1;
         busy_reg <= 1'b0;
         forced_reg <= 1'b0;
         TEMP_FORCE_CONVERSION_REQ <= 1'b0;
      end else begin
         TEMP_FORCE_CONVERSION_REQ <= force_conversion_start;
         if (force_conversion_start) begin
            powerup_reg <= 1'b0;
            busy_reg <= 1'b1;
            forced_reg <= FORCE_CONVERSION;
         end else if (COMP_IDLE) begin
            busy_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Temperature result and trim application

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         temp_reg <= `RSTI_RST_TEMP;
         TRIM_APPLY <= 1'b0;
         CAP_TRIM <= `RSTI_RST_AGING;
      end else begin
         TRIM_APPLY <= 1'b0;
         if (TEMP_DONE) begin
            temp_reg <= TEMP_CODE;
            if (forced_reg || (TEMP_CODE != temp_reg)) begin
               TRIM_APPLY <= 1'b1;
               CAP_TRIM <= aging_reg;
            end
         end
      end
   end

endmodule : rsti_top

//--- sim/rsti_master.sv
`timescale 1ns/1ns
module rsti_master (
   // Bus pins seen from the master
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   // Clock stands high and data is released outside frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // Also a repeated start; waits out the slave's late release of its ack
   task automatic start();
      sda_low = 1'b0;
      #16 scl = 1'b1;
      #12 sda_low = 1'b1;
      #12 scl = 1'b0;
      #8;
   endtask : start

   task automatic stop();
      sda_low = 1'b1;
      #16 scl = 1'b1;
      #12 sda_low = 1'b0;
      #20;
   endtask : stop

   task automatic bit_x(input logic b, output logic r);
      sda_low = ~b;
      #16 scl = 1'b1;
      r = sda;
      #8 scl = 1'b0;
      #8;
   endtask : bit_x

   // A 1 in ack_in releases the line for the slave's ack, or withholds ours
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
         output logic ack_out);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], q[i]);
      end
      bit_x(ack_in, ack_out);
   endtask : xfer
endmodule : rsti_master

//--- sim/rsti_properties.sv
`timescale 1ns/1ns
module rsti_properties (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST,
   // Serial bus
   input wire logic SCL,
   input wire logic SDA_O,
   input wire logic SDA_OE,
   // Fixed clock pin
   input wire logic OSC_WAVE_32K,
   input wire logic FIXED_CLK_O,
   input wire logic FIXED_CLK_OE,
   // Alarm and interrupt pin
   input wire logic SECOND_ALARM_MATCH,
   input wire logic SECOND_ALARM_IRQ_ENABLE,
   input wire logic IRQ_OR_WAVE_SELECT,
   input wire logic IRQ_WAVE_PIN_OE,
   // Conversion
   input wire logic FORCE_CONVERSION,
   input wire logic COMP_IDLE,
   input wire logic TEMP_DONE,
   input wire logic TEMP_FORCE_CONVERSION_REQ,
   input wire logic TRIM_APPLY
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);

   // Busy mirror; cleared eagerly so it never claims busy when the design is not
   logic busy_reg;
   logic busy_next;
   logic busy_now;
   assign busy_next = ~COMP_IDLE & (TEMP_FORCE_CONVERSION_REQ | busy_reg);
   assign busy_now = TEMP_FORCE_CONVERSION_REQ | busy_reg;
   always_ff @(posedge CORE_CLK) begin
      busy_reg <= RST ? 1'b0 : busy_next;
   end

   ////////////////////////////////////////
   sequence s_alarm2_armed;
      SECOND_ALARM_MATCH ##1 (SECOND_ALARM_IRQ_ENABLE && IRQ_OR_WAVE_SELECT) [*2];
   endsequence

   AST_SDA_PULL_LOW: assert property (SDA_OE |-> !SDA_O)
      else $error("data pin driven high");
   AST_SDA_MOVES_LOW: assert property ($changed(SDA_OE) |-> !SCL)
      else $error("data pin moved while bus clock high");
   AST_CLK_COPY: assert property (FIXED_CLK_OE |-> FIXED_CLK_O == $past(OSC_WAVE_32K, 3))
      else $error("fixed clock output not a copy of the wave");
   AST_FORCE_CONVERSION_AT_POWERUP: assert property ($fell(RST) |-> ##[0:2] TEMP_FORCE_CONVERSION_REQ)
      else $error("no conversion after reset");
   AST_REQ_SINGLE: assert property (TEMP_FORCE_CONVERSION_REQ |=> !TEMP_FORCE_CONVERSION_REQ)
      else $error("conversion request longer than one cycle");
   AST_BUSY_REFUSES: assert property (FORCE_CONVERSION && busy_now && !COMP_IDLE |=> !TEMP_FORCE_CONVERSION_REQ)
      else $error("forced conversion taken while busy");
   AST_TRIM_AFTER_DONE: assert property (TRIM_APPLY |-> $past(TEMP_DONE) || $past(TEMP_DONE, 2))
      else $error("trim applied without a finished conversion");
   AST_IRQ_ON_ALARM2: assert property (s_alarm2_armed |-> IRQ_WAVE_PIN_OE)
      else $error("interrupt pin not asserted on second alarm");
endmodule : rsti_properties

//--- sim/rsti_top_tb.sv
`timescale 1ns/1ns
module rsti_top_tb;
   logic core_clk, rst, scl, sda_i, sda_o, sda_oe, sda_low, osc_run, wave, fclk_o, fclk_oe;
   logic a1m, a2m, second_alarm_irq_enable, sel, irq_oe, force_cv, idle, done, req, trim_ap, a, on_batt;
   logic [9:0] tcode;
   logic [7:0] cap, q;
   logic [7:0] rb [4];
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   bit hit;

   rsti_top #(.CYCLES_PER_SEC(1000), .FORCE_CONVERSION_PERIOD_S(4)) i_dut (
      .CORE_CLK(core_clk), .RST(rst), .SCL(scl), .SDA_I(sda_i), .SDA_O(sda_o),
      .SDA_OE(sda_oe), .OSC_RUNNING(osc_run), .OSC_WAVE_32K(wave), .FIXED_CLK_O(fclk_o),
      .FIXED_CLK_OE(fclk_oe), .FIRST_ALARM_MATCH(a1m), .SECOND_ALARM_MATCH(a2m),
      .FIRST_ALARM_IRQ_ENABLE(1'b0), .SECOND_ALARM_IRQ_ENABLE(second_alarm_irq_enable),
      .IRQ_OR_WAVE_SELECT(sel), .IRQ_WAVE_PIN_OE(irq_oe), .ON_BATTERY(on_batt),
      .FORCE_CONVERSION(force_cv), .COMP_IDLE(idle), .TEMP_DONE(done), .TEMP_CODE(tcode),
      .TEMP_FORCE_CONVERSION_REQ(req), .TRIM_APPLY(trim_ap), .CAP_TRIM(cap));
   rsti_master i_mst (.scl(scl), .sda_low(sda_low), .sda(sda_i));
   // Open-drain data line with pull-up
   assign sda_i = ~(sda_low | (sda_oe & ~sda_o));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // Odd-time edges keep the wave off the sampling edge
   initial begin
      wave = 1'b0;
      #1;
      forever #14 wave = ~wave;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         fails++;
         $display("ERROR timeout");
         wrap_up();
      end
   end

   ////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic pulse(ref logic s);
      @(negedge core_clk) s = 1'b1;
      @(negedge core_clk) s = 1'b0;
   endtask : pulse

   task automatic wait_hi(ref logic s, input int lim, output bit h);
      h = 1'b0;
      repeat (lim) begin
         if (s === 1'b1) begin
            h = 1'b1;
            break;
         end
         @(negedge core_clk);
      end
   endtask : wait_hi

   task automatic open(input logic [7:0] b, output logic ack);
      logic [7:0] x;
      @(negedge core_clk);
      #1;
      i_mst.start();
      i_mst.xfer(b, 1'b1, x, ack);
   endtask : open

   task automatic reg_wr(input logic [7:0] p, input logic [7:0] d);
      logic [7:0] x;
      logic k;
      open(8'hd0, k);
      chk("write addr ack", 8'h00, {7'h00, k});
      i_mst.xfer(p, 1'b1, x, k);
      chk("pointer ack", 8'h00, {7'h00, k});
      i_mst.xfer(d, 1'b1, x, k);
      chk("data ack", 8'h00, {7'h00, k});
      i_mst.stop();
   endtask : reg_wr

   task automatic rd(input logic [7:0] p, input bit setp, input int n);
      logic [7:0] x;
      logic k;
      if (setp) begin
         open(8'hd0, k);
         i_mst.xfer(p, 1'b1, x, k);
         i_mst.start();
         i_mst.xfer(8'hd1, 1'b1, x, k);
      end else begin
         open(8'hd1, k);
      end
      chk("read addr ack", 8'h00, {7'h00, k});
      for (int i = 0; i < n; i++) begin
         i_mst.xfer(8'hff, i == n - 1, rb[i], k);
      end
      i_mst.stop();
   endtask : rd

   task automatic wrap_up();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////
   initial begin
      rst = 1'b1;
      {osc_run, sel, second_alarm_irq_enable} = 3'b111;
      {a1m, a2m, force_cv, idle, done, on_batt} = 6'h00;
      tcode = 10'h000;
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      rd(8'h0f, 1, 4);
      chk("status", 8'h8c, rb[0]);
      chk("aging", 8'h00, rb[1]);
      chk("temp int", 8'h00, rb[2]);
      chk("temp frac", 8'h00, rb[3]);
      chk("clk oe", 8'h01, {7'h00, fclk_oe});
      $display("test reset done");

      reg_wr(8'h10, 8'hfd);
      pulse(force_cv);
      wait_hi(req, 4, hit);
      chk("refused req", 8'h00, {7'h00, hit});
      pulse(idle);
      pulse(force_cv);
      wait_hi(req, 4, hit);
      chk("forced req", 8'h01, {7'h00, hit});
      rd(8'h0f, 1, 1);
      chk("status busy", 8'h8c, rb[0]);
      tcode = 10'h065;
      pulse(done);
      wait_hi(trim_ap, 4, hit);
      chk("trim apply", 8'h01, {7'h00, hit});
      chk("cap trim", 8'hfd, cap);
      reg_wr(8'h11, 8'h55);
      rd(8'h00, 0, 1);
      chk("pointer resume", 8'h40, rb[0]);
      rd(8'h10, 1, 3);
      chk("aging", 8'hfd, rb[0]);
      chk("temp int", 8'h19, rb[1]);
      chk("temp frac", 8'h40, rb[2]);
      $display("test conversion done");

      pulse(a1m);
      pulse(a2m);
      repeat (2) @(negedge core_clk);
      chk("irq pin", 8'h01, {7'h00, irq_oe});
      rd(8'h0f, 1, 1);
      chk("flags set", 8'h8f, rb[0]);
      reg_wr(8'h0f, 8'h7f);
      rd(8'h0f, 1, 1);
      chk("write ones", 8'h0f, rb[0]);
      reg_wr(8'h0f, 8'h08);
      rd(8'h0f, 1, 1);
      chk("write zeros", 8'h0c, rb[0]);
      chk("irq pin off", 8'h00, {7'h00, irq_oe});
      $display("test flags done");

      osc_run = 1'b0;
      repeat (10) @(negedge core_clk);
      chk("clk oe stopped", 8'h00, {7'h00, fclk_oe});
      osc_run = 1'b1;
      rd(8'h0f, 1, 1);
      chk("osc stop flag", 8'h8c, rb[0]);
      reg_wr(8'h0f, 8'h00);
      repeat (4) @(negedge core_clk);
      chk("clk oe off", 8'h00, {7'h00, fclk_oe});
      reg_wr(8'h0f, 8'h08);
      repeat (4) @(negedge core_clk);
      chk("clk oe on", 8'h01, {7'h00, fclk_oe});
      open(8'hd2, a);
      i_mst.stop();
      chk("wrong addr", 8'h01, {7'h00, a});
      $display("test pins done");

      // Bus access on backup supply starts a conversion, seen as busy
      pulse(idle);
      on_batt = 1'b1;
      rd(8'h0f, 1, 1);
      chk("battery access busy", 8'h0c, rb[0]);
      on_batt = 1'b0;
      pulse(idle);
      wait_hi(req, 4100, hit);
      chk("periodic req", 8'h01, {7'h00, hit});
      $display("test period done");
      wrap_up();
   end
endmodule : rsti_top_tb

bind rsti_top rsti_properties i_prop (
   .CORE_CLK(CORE_CLK), .RST(RST), .SCL(SCL), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
   .OSC_WAVE_32K(OSC_WAVE_32K), .FIXED_CLK_O(FIXED_CLK_O), .FIXED_CLK_OE(FIXED_CLK_OE),
   .SECOND_ALARM_MATCH(SECOND_ALARM_MATCH), .SECOND_ALARM_IRQ_ENABLE(SECOND_ALARM_IRQ_ENABLE),
   .IRQ_OR_WAVE_SELECT(IRQ_OR_WAVE_SELECT), .IRQ_WAVE_PIN_OE(IRQ_WAVE_PIN_OE),
   .FORCE_CONVERSION(FORCE_CONVERSION), .COMP_IDLE(COMP_IDLE), .TEMP_DONE(TEMP_DONE),
   .TEMP_FORCE_CONVERSION_REQ(TEMP_FORCE_CONVERSION_REQ), .TRIM_APPLY(TRIM_APPLY));
